// [rtl/seiu_regs.svh]
`ifndef SEIU_REGS_SVH
`define SEIU_REGS_SVH

// Register indices; byte address is four times the index
`define SEIU_IDX_PENDING 6'h04
`define SEIU_IDX_MASK 6'h05
`define SEIU_IDX_SETUP 6'h10

// Reset values
`define SEIU_PENDING_RST 8'h00
`define SEIU_MASK_RST 8'hff
`define SEIU_SETUP_RST 8'h00

// Event bit positions
`define SEIU_BIT_DISRUPT 4
`define SEIU_BIT_SETTLED 5
`define SEIU_BIT_VSYNC 6
`define SEIU_BIT_PHASE 7

// Status bits that can ever be set (bit 3 reserved)
`define SEIU_PENDING_LIVE 8'hf7

// Input setup field positions
`define SEIU_SETUP_CLAMP_SRC 6
`define SEIU_SETUP_CLAMP_POL 7

// Bus responses
`define SEIU_RESP_OKAY 2'h0
`define SEIU_RESP_SLVERR 2'h2

`endif

// [rtl/seiu_pkg.sv]
package seiu_pkg;

	typedef struct packed
	{
		logic [2:0] hsync;
		logic [2:0] vsync;
		logic [2:0] greenEmbeddedSync;
		logic extClamp;
	} seiu_pins_t;

	typedef struct packed
	{
		logic [2:0] chSyncChange;
		logic [2:0] chDisrupt;
		logic [2:0] chSettled;
		logic phaseTuneDoneEvent;
		logic intClamp;
	} seiu_events_t;

	typedef struct packed
	{
		logic [1:0] videoSel;
		logic hsync;
		logic vsync;
		logic greenEmbeddedSync;
		logic clamp;
	} seiu_route_t;

	typedef enum logic {WR_COLLECT, WR_RESP} seiu_wrph_t;

	typedef struct packed
	{
		seiu_pins_t meta;
		seiu_pins_t stable;
	} seiu_sync_st_t;

	typedef struct packed
	{
		seiu_wrph_t wrPh;
		logic awHeld;
		logic wHeld;
		logic [5:0] awIdx;
		logic [7:0] wData;
		logic wLane0;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [7:0] rdata;
		logic [1:0] rresp;
		logic [7:0] pending;
		logic [7:0] mask;
		logic [7:0] setup;
		seiu_route_t route;
		logic irq;
	} seiu_state_t;

endpackage

// [rtl/seiu_sync.sv]
`timescale 1ns/1ps
`default_nettype none

module seiu_sync
	import seiu_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire seiu_pins_t pinsAsync,
	output seiu_pins_t pinsStable
);

	seiu_sync_st_t st_q;
	seiu_sync_st_t st_d;

	// First stage feeds only the second stage
	always_comb
	begin
		st_d.meta = pinsAsync;
		st_d.stable = st_q.meta;
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st_q <= '0;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign pinsStable = st_q.stable;

endmodule

`default_nettype wire

// [rtl/seiu_top.sv]
// Functional notes
// - Channel sync change sets status bits 0-2
// - Writing ones clears status; zeros untouched
// - Selected channel disruption sets status bit 4
// - Selected channel settling sets status bit 5
// - Selected channel vertical sync rising edge sets status bit 6
// - Phase adjustment completion sets status bit 7
// - Mask bits 0-2 gate channel interrupts
// - Mask bit 4 gates disruption interrupt
// - Mask bit 5 gates settling interrupt
// - Mask bit 7 gates phase-done interrupt
// - Channel select routes video, hsync, vsync and embedded-sync multiplexers
// - Setup bit 6 picks external clamp source
// - Setup bit 7 sets external clamp polarity
`timescale 1ns/1ps
`default_nettype none
`include "seiu_regs.svh"

module seiu_top
	import seiu_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire seiu_pins_t syncPins,
	input wire seiu_events_t events,
	output seiu_route_t routeOut,
	output logic irqOut
);

	seiu_state_t st_q;
	seiu_state_t st_d;
	seiu_pins_t pinsStable;
	logic [7:0] setEv;
	logic [7:0] clrEv;
	logic commitPend;

	// Channel pick; reserved code 3 falls back to channel 0
	function automatic logic pickChan(input logic [2:0] vec, input logic [1:0] sel);
		logic res;
		res = vec[0];
		if (sel == 2'h1)
		begin
			res = vec[1];
		end
		else if (sel == 2'h2)
		begin
			res = vec[2];
		end
		return res;
	endfunction

	function automatic logic isMapped(input logic [5:0] idx);
		logic res;
		res = 1'b0;
		if (idx == `SEIU_IDX_PENDING)
		begin
			res = 1'b1;
		end
		else if (idx == `SEIU_IDX_MASK)
		begin
			res = 1'b1;
		end
		else if (idx == `SEIU_IDX_SETUP)
		begin
			res = 1'b1;
		end
		return res;
	endfunction

	function automatic logic clampPick(input logic [7:0] setup, input logic ext,
		input logic intClamp);
		logic res;
		res = intClamp;
		if (setup[`SEIU_SETUP_CLAMP_SRC])
		begin
			res = ext ^ setup[`SEIU_SETUP_CLAMP_POL];
		end
		return res;
	endfunction

	seiu_sync u_sync
	(
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.pinsAsync(syncPins),
		.pinsStable(pinsStable)
	);

	assign commitPend = st_q.awHeld && st_q.wHeld && st_q.wLane0
		&& (st_q.awIdx == `SEIU_IDX_PENDING);

	always_comb
	begin
		st_d = st_q;
		setEv = 8'h00;
		clrEv = 8'h00;

		// Read channel
		if (s_axi_arvalid && st_q.arready)
		begin
			st_d.rvalid = 1'b1;
			st_d.rresp = `SEIU_RESP_SLVERR;
			st_d.rdata = 8'h00;
			if (s_axi_araddr[7:2] == `SEIU_IDX_PENDING)
			begin
				st_d.rdata = st_q.pending & `SEIU_PENDING_LIVE;
				st_d.rresp = `SEIU_RESP_OKAY;
			end
			else if (s_axi_araddr[7:2] == `SEIU_IDX_MASK)
			begin
				st_d.rdata = st_q.mask;
				st_d.rresp = `SEIU_RESP_OKAY;
			end
			else if (s_axi_araddr[7:2] == `SEIU_IDX_SETUP)
			begin
				st_d.rdata = st_q.setup;
				st_d.rresp = `SEIU_RESP_OKAY;
			end
		end
		else if (st_q.rvalid && s_axi_rready)
		begin
			st_d.rvalid = 1'b0;
		end
		st_d.arready = !st_d.rvalid;

		// Write address and data, either order
		if (s_axi_awvalid && st_q.awready)
		begin
			st_d.awHeld = 1'b1;
			st_d.awIdx = s_axi_awaddr[7:2];
		end
		if (s_axi_wvalid && st_q.wready)
		begin
			st_d.wHeld = 1'b1;
			st_d.wData = s_axi_wdata[7:0];
			st_d.wLane0 = s_axi_wstrb[0];
		end

		case (st_q.wrPh)
			WR_COLLECT:
			begin
				if (st_q.awHeld && st_q.wHeld)
				begin
					st_d.awHeld = 1'b0;
					st_d.wHeld = 1'b0;
					st_d.bvalid = 1'b1;
					st_d.wrPh = WR_RESP;
					st_d.bresp = isMapped(st_q.awIdx) ? `SEIU_RESP_OKAY : `SEIU_RESP_SLVERR;
					if (st_q.wLane0 && (st_q.awIdx == `SEIU_IDX_MASK))
					begin
						st_d.mask = st_q.wData;
					end
					else if (st_q.wLane0 && (st_q.awIdx == `SEIU_IDX_SETUP))
					begin
						st_d.setup = st_q.wData;
					end
					if (commitPend)
					begin
						clrEv = st_q.wData;
					end
				end
			end
			WR_RESP:
			begin
				if (s_axi_bready)
				begin
					st_d.bvalid = 1'b0;
					st_d.wrPh = WR_COLLECT;
				end
			end
			default:
			begin
				st_d.wrPh = WR_COLLECT;
			end
		endcase
		st_d.awready = !st_d.awHeld && (st_d.wrPh == WR_COLLECT);
		st_d.wready = !st_d.wHeld && (st_d.wrPh == WR_COLLECT);

		// Event capture
		setEv[2:0] = events.chSyncChange;
		setEv[`SEIU_BIT_DISRUPT] = pickChan(events.chDisrupt, st_q.setup[1:0]);
		setEv[`SEIU_BIT_SETTLED] = pickChan(events.chSettled, st_q.setup[1:0]);
		setEv[`SEIU_BIT_VSYNC] = pickChan(pinsStable.vsync, st_q.setup[1:0])
			& ~st_q.route.vsync;
		setEv[`SEIU_BIT_PHASE] = events.phaseTuneDoneEvent;

		// Set wins over a clear in the same cycle
		st_d.pending = ((st_q.pending & ~clrEv) | setEv) & `SEIU_PENDING_LIVE;

		// Input routing follows the current channel select
		st_d.route.videoSel = st_q.setup[1:0];
		st_d.route.hsync = pickChan(pinsStable.hsync, st_q.setup[1:0]);
		st_d.route.vsync = pickChan(pinsStable.vsync, st_q.setup[1:0]);
		st_d.route.greenEmbeddedSync = pickChan(pinsStable.greenEmbeddedSync,
			st_q.setup[1:0]);
		st_d.route.clamp = clampPick(st_q.setup, pinsStable.extClamp,
			events.intClamp);

		// A one in a mask bit suppresses that request
		st_d.irq = |(st_d.pending & ~st_d.mask);
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st_q <= '0;
			st_q.wrPh <= WR_COLLECT;
			st_q.pending <= `SEIU_PENDING_RST;
			st_q.mask <= `SEIU_MASK_RST;
			st_q.setup <= `SEIU_SETUP_RST;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign s_axi_awready = st_q.awready;
	assign s_axi_wready = st_q.wready;
	assign s_axi_bvalid = st_q.bvalid;
	assign s_axi_bresp = st_q.bresp;
	assign s_axi_arready = st_q.arready;
	assign s_axi_rvalid = st_q.rvalid;
	assign s_axi_rdata = {24'h000000, st_q.rdata};
	assign s_axi_rresp = st_q.rresp;
	assign routeOut = st_q.route;
	assign irqOut = st_q.irq;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);

	sequence s_pendWrite;
		commitPend && (st_q.wrPh == WR_COLLECT);
	endsequence

	sequence s_noSets;
		(events.chSyncChange == 3'h0) && !events.phaseTuneDoneEvent
			&& (events.chDisrupt == 3'h0) && (events.chSettled == 3'h0)
			&& (pinsStable.vsync == 3'h0);
	endsequence

	property p_chanSet;
		(events.chSyncChange != 3'h0) |=>
			((st_q.pending[2:0] & $past(events.chSyncChange)) == $past(events.chSyncChange));
	endproperty
	a_chanSet: assert property (p_chanSet) else $error("channel change not latched");

	property p_w1c;
		(s_pendWrite and s_noSets) |=>
			(st_q.pending == ($past(st_q.pending) & ~$past(st_q.wData)));
	endproperty
	a_w1c: assert property (p_w1c) else $error("write-one clear wrong");

	property p_disrupt;
		pickChan(events.chDisrupt, st_q.setup[1:0]) |=> st_q.pending[`SEIU_BIT_DISRUPT];
	endproperty
	a_disrupt: assert property (p_disrupt) else $error("disruption not latched");

	property p_settled;
		pickChan(events.chSettled, st_q.setup[1:0]) |=> st_q.pending[`SEIU_BIT_SETTLED];
	endproperty
	a_settled: assert property (p_settled) else $error("settling not latched");

	property p_vsync;
		$rose(st_q.route.vsync) |-> st_q.pending[`SEIU_BIT_VSYNC];
	endproperty
	a_vsync: assert property (p_vsync) else $error("vertical sync not latched");

	property p_phase;
		events.phaseTuneDoneEvent |=> st_q.pending[`SEIU_BIT_PHASE];
	endproperty
	a_phase: assert property (p_phase) else $error("phase done not latched");

	property p_irqOn;
		((st_q.pending & ~st_q.mask) != 8'h00) |-> irqOut;
	endproperty
	a_irqOn: assert property (p_irqOn) else $error("unmasked event without request");

	property p_irqOff;
		((st_q.pending & ~st_q.mask) == 8'h00) |-> !irqOut;
	endproperty
	a_irqOff: assert property (p_irqOff) else $error("masked event raised request");

	property p_sticky;
		(st_q.pending[`SEIU_BIT_SETTLED] && !commitPend) |=> st_q.pending[`SEIU_BIT_SETTLED];
	endproperty
	a_sticky: assert property (p_sticky) else $error("status bit dropped");

	property p_route;
		##1 (routeOut.hsync == pickChan($past(pinsStable.hsync), $past(st_q.setup[1:0])))
			&& (routeOut.videoSel == $past(st_q.setup[1:0]));
	endproperty
	a_route: assert property (p_route) else $error("input routing wrong");

	property p_clamp;
		##1 routeOut.clamp == clampPick($past(st_q.setup), $past(pinsStable.extClamp),
			$past(events.intClamp));
	endproperty
	a_clamp: assert property (p_clamp) else $error("clamp source wrong");

	property p_phaseIrq;
		(events.phaseTuneDoneEvent && !st_q.mask[`SEIU_BIT_PHASE]
			&& !(st_q.awHeld && st_q.wHeld)) |=> irqOut;
	endproperty
	a_phaseIrq: assert property (p_phaseIrq) else $error("phase request missing");

	property p_settleIrq;
		(pickChan(events.chSettled, st_q.setup[1:0]) && !st_q.mask[`SEIU_BIT_SETTLED]
			&& !(st_q.awHeld && st_q.wHeld)) |=> irqOut;
	endproperty
	a_settleIrq: assert property (p_settleIrq) else $error("settle request missing");

	property p_bresp;
		(st_q.awHeld && st_q.wHeld && (st_q.wrPh == WR_COLLECT)) |=> s_axi_bvalid [*1];
	endproperty
	a_bresp: assert property (p_bresp) else $error("write response missing");

endmodule

`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "seiu_regs.svh"

module testbench
	import seiu_pkg::*;
();

localparam logic [7:0] P = {`SEIU_IDX_PENDING, 2'b00};
localparam logic [7:0] M = {`SEIU_IDX_MASK, 2'b00};
localparam logic [7:0] S = {`SEIU_IDX_SETUP, 2'b00};
localparam logic [1:0] OK = `SEIU_RESP_OKAY;
localparam logic [1:0] ERR = `SEIU_RESP_SLVERR;

logic ref_clk, sys_rst, irqOut;
logic [7:0] awaddr, araddr, pend, r, s;
logic awvalid, awready, wvalid, wready, bvalid, bready;
logic arvalid, arready, rvalid, rready;
logic [31:0] wdata, rdata;
logic [1:0] bresp, rresp;
logic [3:0] strb;
logic [5:0] e;
seiu_pins_t pins;
seiu_events_t ev;
seiu_route_t route;
int n_errors, cmp_count, cyc;
logic [33:0] rq[$];
logic [1:0] bq[$];

seiu_top DUT (
	.ref_clk(ref_clk), .sys_rst(sys_rst),
	.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
	.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
	.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
	.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
	.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
	.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
	.s_axi_rready(rready), .syncPins(pins), .events(ev), .routeOut(route),
	.irqOut(irqOut)
);

initial
begin
	ref_clk = 1'b0;
	forever #5 ref_clk = ~ref_clk;
end

task complete_run;
	$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
	if (n_errors == 0 && cmp_count > 0)
		$display("bench passed");
	else
		$display("bench failed");
	$finish;
endtask

task tally(input bit bad, input logic [33:0] g, input logic [33:0] x);
	cmp_count++;
	if (bad)
	begin
		n_errors++;
		$display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
	end
endtask

task chkRd(input logic [33:0] g, input logic [33:0] x);
	tally(g !== x, g, x);
endtask

task chkResp(input logic [1:0] g, input logic [1:0] x);
	tally(g !== x, {32'h0, g}, {32'h0, x});
endtask

task chkOut(input logic [7:0] g, input logic [7:0] x);
	tally(g !== x, {26'h0, g}, {26'h0, x});
endtask

// Responses are judged where they appear
always @(posedge ref_clk)
begin
	if (rvalid && rready)
		chkRd({rresp, rdata}, rq.pop_front());
	if (bvalid && bready)
		chkResp(bresp, bq.pop_front());
end

always @(posedge ref_clk)
begin
	cyc++;
	if (cyc == 6000)
	begin
		n_errors++;
		complete_run();
	end
end

task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] x);
	bit aw;
	bit w;
	aw = 1'b1;
	w = 1'b1;
	bq.push_back(x);
	awaddr <= a;
	wdata <= {24'h0, d};
	awvalid <= 1'b1;
	wvalid <= 1'b1;
	bready <= 1'b1;
	while (aw || w)
	begin
		@(posedge ref_clk);
		if (aw && awready)
			awvalid <= 1'b0;
		if (w && wready)
			wvalid <= 1'b0;
		aw = aw && !awready;
		w = w && !wready;
	end
	do @(posedge ref_clk); while (!bvalid);
	bready <= 1'b0;
	@(posedge ref_clk);
endtask

task rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] x);
	rq.push_back({x, 24'h0, d});
	araddr <= a;
	arvalid <= 1'b1;
	rready <= 1'b1;
	do @(posedge ref_clk); while (!arready);
	arvalid <= 1'b0;
	do @(posedge ref_clk); while (!rvalid);
	rready <= 1'b0;
	@(posedge ref_clk);
endtask

task pulse(input seiu_events_t v);
	ev <= v;
	@(posedge ref_clk);
	ev <= '0;
	repeat (2) @(posedge ref_clk);
endtask

initial
begin
	{awvalid, wvalid, bready, arvalid, rready} = '0;
	{awaddr, araddr, wdata} = '0;
	strb = 4'h1;
	pins = '0;
	ev = '0;
	sys_rst = 1'b1;
	void'($urandom(32'h7d8d));
	repeat (5) @(posedge ref_clk);
	sys_rst <= 1'b0;
	repeat (2) @(posedge ref_clk);
	chkOut({7'h0, irqOut}, 8'h00);
	rd(P, `SEIU_PENDING_RST, OK);
	rd(M, `SEIU_MASK_RST, OK);
	rd(S, `SEIU_SETUP_RST, OK);
	wr(8'h08, 8'h5a, ERR);
	rd(8'h08, 8'h00, ERR);
	$display("test reset done");

	r = 8'($urandom);
	pulse('{chSyncChange: r[2:0], chDisrupt: 3'b110, chSettled: 3'b110, default: '0});
	rd(P, {5'h0, r[2:0]}, OK);
	pulse('{chDisrupt: 3'b001, chSettled: 3'b001, phaseTuneDoneEvent: 1'b1, default: '0});
	pend = 8'hb0 | {5'h0, r[2:0]};
	rd(P, pend, OK);
	pins.vsync[0] <= 1'b1;
	repeat (6) @(posedge ref_clk);
	pend[6] = 1'b1;
	rd(P, pend, OK);
	chkOut({7'h0, irqOut}, 8'h00);
	for (int i = 0; i < 8; i++)
	begin
		wr(M, ~(8'h01 << i) | 8'h08, OK);
		repeat (2) @(posedge ref_clk);
		chkOut({7'h0, irqOut}, {7'h0, pend[i]});
	end
	$display("test events done");

	r = 8'($urandom);
	wr(P, r, OK);
	pend = pend & ~r;
	rd(P, pend, OK);
	repeat (2) @(posedge ref_clk);
	chkOut({7'h0, irqOut}, {7'h0, pend[7]});
	wr(P, 8'hff, OK);
	rd(P, 8'h00, OK);
	repeat (2) @(posedge ref_clk);
	chkOut({7'h0, irqOut}, 8'h00);
	// Write with lane 0 disabled must leave the mask alone
	strb <= 4'h0;
	wr(M, 8'h00, OK);
	strb <= 4'h1;
	rd(M, 8'h7f, OK);
	$display("test clear done");

	for (int c = 0; c < 3; c++)
		for (int k = 0; k < 4; k++)
		begin
			r = 8'($urandom);
			s = {k[1:0], r[5:3], r[2] & (c != 2), c[1:0]};
			wr(S, s, OK);
			pins <= 10'($urandom);
			ev.intClamp <= r[7];
			repeat (5) @(posedge ref_clk);
			e = {c[1:0], pins.hsync[c], pins.vsync[c], pins.greenEmbeddedSync[c],
				k[0] ? pins.extClamp ^ k[1] : r[7]};
			chkOut({2'h0, route}, {2'h0, e});
			rd(S, s, OK);
		end
	$display("test routing done");
	complete_run();
end

endmodule
`default_nettype wire
